// file: core/pic_top.sv
// Prioritised interrupt controller with Wishbone register access.
`default_nettype none
module pic_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        fast_request_pin_i,
  input  wire logic [7:0]  ext_request_pins_i,
  input  wire logic [12:0] int_events_i,
  input  wire logic        stop_mode_i,
  output logic             fast_exception_req_n_o,
  output logic             normal_exception_req_n_o
);
  logic [7:0]  current_level_mask;
  logic [2:0]  pending_level;
  logic [4:0]  active_source_number;
  logic        fast_mask_bit;
  logic        fast_request_flag;
  logic [7:0]  pin_sensing_select;
  logic [15:0] request_flags_low;
  logic [7:0]  request_flags_high;
  logic [15:0] level_fields [6];
  logic [71:0] level_flat;
  logic [7:0]  ext_trig;
  logic        fast_level;
  logic        fast_trig;
  logic        fast_prev;
  logic        fast_event;
  logic [23:0] pending;
  logic [2:0]  cur_top;
  logic        req_ok;
  logic        wr;
  logic        rd;
  logic        number_read;
  logic [31:0] next_dat;
  pic_pkg::pic_select_type choice;

  function automatic logic [2:0] top_level(input logic [7:0] m);
    top_level = 3'h0;
    for (int k = 1; k < 8; k++) begin
      if (m[k]) begin
        top_level = 3'(k);
      end
    end
  endfunction

  function automatic logic [15:0] w1c16(input logic [15:0] v,
                                        input logic [15:0] d);
    w1c16 = v & ~d;
  endfunction

  // Single-cycle answer; ack falls the cycle after it rose.
  assign req_ok = cyc_i && stb_i && !ack_o;
  assign wr = req_ok && we_i;
  assign rd = req_ok && !we_i;
  assign number_read = rd && adr_i == pic_pkg::ADR_NUMBER;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req_ok;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      pic_pin_sense u_sense (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .pin_n_i     (ext_request_pins_i[g]),
        .edge_mode_i (pin_sensing_select[g]),
        .stop_mode_i (stop_mode_i),
        .level_o     (),
        .trigger_o   (ext_trig[g])
      );
    end
    for (g = 0; g < 6; g++) begin : g_lvl
      assign level_flat[g*12 +: 12] = {level_fields[g][14:12],
                                       level_fields[g][10:8],
                                       level_fields[g][6:4],
                                       level_fields[g][2:0]};
    end
  endgenerate

  // Fast pin is always treated as edge sensed outside stop mode.
  pic_pin_sense u_fast (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .pin_n_i     (fast_request_pin_i),
    .edge_mode_i (1'b1),
    .stop_mode_i (stop_mode_i),
    .level_o     (fast_level),
    .trigger_o   (fast_trig)
  );

  // In stop mode a held low level sets the flag every cycle, even after a clear; outside it only an edge sets it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_prev <= 1'b0;
    end else begin
      fast_prev <= fast_trig;
    end
  end
  assign fast_event = fast_trig && (!fast_prev || stop_mode_i);

  assign pending = {request_flags_high, request_flags_low};

  pic_arbiter u_arb (
    .pending_i (pending),
    .levels_i  (level_flat),
    .sel_o     (choice)
  );

  assign cur_top = top_level(current_level_mask);

  // Latch selection; a number read clears the pending level.
  // The pending level also falls back to zero once nothing outranks the
  // current level, so a cleared request never leaves a stale level behind.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_level <= pic_pkg::PEND_LEVEL_RST; // RULE14
      active_source_number <= 5'h00;
    end else if (number_read) begin
      pending_level <= pic_pkg::PEND_LEVEL_RST; // RULE11
    end else if (choice.hit && choice.level > cur_top) begin // RULE1 RULE12
      pending_level <= choice.level; // RULE14
      active_source_number <= choice.number;
    end else begin
      pending_level <= pic_pkg::PEND_LEVEL_RST; // RULE14
    end
  end

  // Held requests release once the current level drops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_exception_req_n_o <= 1'b1;
    end else begin
      normal_exception_req_n_o <= !(choice.hit && choice.level > cur_top
                                    && !number_read); // RULE1 RULE22
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_level_mask <= pic_pkg::CUR_LEVEL_RST;
    end else if (number_read) begin
      current_level_mask <= current_level_mask
                            | (8'h01 << pending_level); // RULE10 RULE22
    end else if (wr && adr_i == pic_pkg::ADR_CUR_LEVEL && sel_i[0]) begin
      current_level_mask <= current_level_mask & ~dat_i[7:0]; // RULE13
    end
  end

  // Set wins over a simultaneous write-one clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_flags_low <= pic_pkg::FLAGS_LOW_RST;
      request_flags_high <= pic_pkg::FLAGS_HIGH_RST;
    end else begin
      request_flags_low <= (wr && adr_i == pic_pkg::ADR_FLAGS_LOW
                            ? w1c16(request_flags_low,
                                    {sel_i[1] ? dat_i[15:8] : 8'h00,
                                     sel_i[0] ? dat_i[7:0] : 8'h00}) // RULE13
                            : request_flags_low)
                           | ({3'h0, int_events_i}
                              & pic_pkg::FLAGS_LOW_VALID); // RULE6 RULE18
      request_flags_high <= (wr && adr_i == pic_pkg::ADR_FLAGS_HIGH
                             && sel_i[0]
                             ? request_flags_high & ~dat_i[7:0] // RULE13
                             : request_flags_high)
                            | ext_trig; // RULE5 RULE6 RULE18
    end
  end

  // Mask resets to 1 whatever the pin level; only the read-back level bit follows the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_mask_bit <= pic_pkg::FAST_MASK_RST; // RULE15
      fast_request_flag <= 1'b0;
    end else begin
      if (wr && adr_i == pic_pkg::ADR_FAST_CTRL && sel_i[0]) begin
        fast_mask_bit <= dat_i[pic_pkg::FAST_MASK_POS]; // RULE15
      end
      fast_request_flag <= (fast_request_flag
                            && !(wr && adr_i == pic_pkg::ADR_FAST_CTRL
                                 && sel_i[0]
                                 && dat_i[pic_pkg::FAST_FLAG_POS])) // RULE17
                           || fast_event; // RULE17 RULE4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_exception_req_n_o <= 1'b1;
    end else begin
      fast_exception_req_n_o <= !(fast_request_flag
                                  && !fast_mask_bit); // RULE2 RULE21
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sensing_select <= pic_pkg::SENSE_RST;
    end else if (wr && adr_i == pic_pkg::ADR_SENSE && sel_i[0]) begin
      pin_sensing_select <= dat_i[7:0]; // RULE5
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int r = 0; r < 6; r++) begin
        level_fields[r] <= pic_pkg::LEVEL_FIELDS_RST; // RULE19
      end
    end else begin
      for (int r = 0; r < 6; r++) begin
        if (wr && adr_i == pic_pkg::ADR_LEVEL_BASE + 6'(r * 4)) begin
          if (sel_i[0]) begin
            level_fields[r][7:0] <= dat_i[7:0]
                                    & pic_pkg::LEVEL_FIELD_MASK[7:0];
          end
          if (sel_i[1]) begin
            level_fields[r][15:8] <= dat_i[15:8]
                                     & pic_pkg::LEVEL_FIELD_MASK[15:8];
          end
        end
      end
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      pic_pkg::ADR_NUMBER: next_dat = {27'h0, active_source_number}; // RULE8
      pic_pkg::ADR_CUR_LEVEL: next_dat = {24'h0, current_level_mask};
      pic_pkg::ADR_PEND_LEVEL: next_dat = {29'h0, pending_level};
      pic_pkg::ADR_FAST_CTRL: next_dat = {29'h0, fast_mask_bit,
                                          fast_level, // RULE16
                                          fast_request_flag};
      pic_pkg::ADR_SENSE: next_dat = {24'h0, pin_sensing_select};
      pic_pkg::ADR_FLAGS_LOW: next_dat = {16'h0, request_flags_low};
      pic_pkg::ADR_FLAGS_HIGH: next_dat = {24'h0, request_flags_high};
      default: begin
        if (adr_i >= pic_pkg::ADR_LEVEL_BASE
            && adr_i <= pic_pkg::ADR_LEVEL_LAST && adr_i[1:0] == 2'h0) begin
          next_dat = {16'h0, level_fields[3'(adr_i[4:2] - 3'h0)]};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else begin
      dat_o <= rd ? next_dat : 32'h0000_0000;
    end
  end

  // Steps shared by the checks below.
  sequence seq_request_above;
    choice.hit && choice.level > cur_top && !number_read;
  endsequence

  sequence seq_answer;
    ack_o ##1 !ack_o;
  endsequence

  sequence seq_fast_clear;
    wr && adr_i == pic_pkg::ADR_FAST_CTRL && sel_i[0]
    && dat_i[pic_pkg::FAST_FLAG_POS] && !fast_event;
  endsequence

  sequence seq_level_clear;
    wr && adr_i == pic_pkg::ADR_CUR_LEVEL && sel_i[0];
  endsequence

  AST_NUMREAD_CLEARS: assert property ( // RULE11
    @(posedge clk_i) disable iff (rst_i)
    number_read |=> pending_level == 3'h0)
    else $error("pending level not cleared by number read");
  AST_NUMREAD_SETS: assert property ( // RULE10
    @(posedge clk_i) disable iff (rst_i)
    number_read |=> current_level_mask[$past(pending_level)])
    else $error("current level bit not set by number read");
  AST_FAST_MASKED: assert property ( // RULE2
    @(posedge clk_i) disable iff (rst_i)
    $past(fast_mask_bit) |-> fast_exception_req_n_o)
    else $error("masked fast request driven");
  AST_FAST_DRIVE: assert property ( // RULE21
    @(posedge clk_i) disable iff (rst_i)
    fast_request_flag && !fast_mask_bit |=> !fast_exception_req_n_o)
    else $error("fast request not driven");
  AST_NORMAL_GATE: assert property ( // RULE12
    @(posedge clk_i) disable iff (rst_i)
    !normal_exception_req_n_o |-> $past(choice.level) > $past(cur_top))
    else $error("normal request at blocked level");
  AST_NEGATE_AFTER_READ: assert property ( // RULE22
    @(posedge clk_i) disable iff (rst_i)
    number_read |=> normal_exception_req_n_o)
    else $error("normal request not negated after number read");
  AST_FLAG_SET: assert property ( // RULE5
    @(posedge clk_i) disable iff (rst_i)
    ext_trig[0] |=> request_flags_high[0])
    else $error("external flag not set");
  AST_RESERVED_ZERO: assert property ( // RULE6
    @(posedge clk_i) disable iff (rst_i)
    request_flags_low[15:13] == 3'h0)
    else $error("reserved flag set");
  AST_PEND_LATCH: assert property ( // RULE14
    @(posedge clk_i) disable iff (rst_i)
    seq_request_above |=> pending_level == $past(choice.level))
    else $error("pending level not latched");
  AST_PEND_IDLE: assert property ( // RULE14
    @(posedge clk_i) disable iff (rst_i)
    !(choice.hit && choice.level > cur_top) |=> pending_level == 3'h0)
    else $error("pending level shown with nothing above current level");
  AST_NUMBER_LATCH: assert property ( // RULE7
    @(posedge clk_i) disable iff (rst_i)
    seq_request_above |=> active_source_number == $past(choice.number))
    else $error("source number not latched");
  AST_NORMAL_DRIVE: assert property ( // RULE1
    @(posedge clk_i) disable iff (rst_i)
    seq_request_above |=> !normal_exception_req_n_o)
    else $error("normal request not driven");
  AST_ACK_PULSE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req_ok |=> seq_answer)
    else $error("ack is not a single-cycle pulse");
  AST_FAST_SET: assert property ( // RULE17
    @(posedge clk_i) disable iff (rst_i)
    fast_event |=> fast_request_flag)
    else $error("fast request flag not set");
  AST_FAST_CLEAR: assert property ( // RULE17
    @(posedge clk_i) disable iff (rst_i)
    seq_fast_clear |=> !fast_request_flag)
    else $error("fast request flag not cleared");
  AST_LEVEL_CLEAR: assert property ( // RULE13
    @(posedge clk_i) disable iff (rst_i)
    seq_level_clear |=> (current_level_mask & $past(dat_i[7:0])) == 8'h00)
    else $error("current level bits not cleared");
endmodule
`default_nettype wire

// file: core/pic_pkg.sv
// Package with register map, field layouts, reset values and carrier types.
// Overview of operation
// RULE1 - Normal source at or below current level stays pending until level drops.
// RULE2 - Unmasked falling edge on fast pin raises fast exception, never level gated.
// RULE3 - Processor takes fast or normal request only while its disable flag is 0.
// RULE4 - In stop mode fast pin and external pins trigger on low level.
// RULE5 - Sensing bit 1 means falling edge, 0 low level; trigger sets upper flag.
// RULE6 - Pins 0..7 are sources 16..23; internal sources 0..12; 13..15 reserved.
// RULE7 - Among equal top levels the larger source number wins.
// RULE8 - Number register is read-only; bits 4:0 hold source, upper bits zero.
// RULE9 - Software reads the number register once per normal exception.
// RULE10 - Number read sets current-level bit indexed by pending level; resets 0.
// RULE11 - Number read clears pending level to zero.
// RULE12 - Highest set current-level bit blocks requests at that level and below.
// RULE13 - Current-level and request-flag registers are write-one-to-clear.
// RULE14 - Pending level shows level of top pending unmasked request; resets 0.
// RULE15 - Fast control bit 2 is mask; resets to 0x04 or 0x06 by pin.
// RULE16 - Fast control bit 1 shows live pin level; writes ignored.
// RULE17 - Fast control bit 0 set by falling edge, cleared by writing 1.
// RULE18 - Each normal request sets its flag; low 16 bits, high 8 bits, reset 0.
// RULE19 - Six level registers, four 3-bit fields each, other bits zero.
// RULE20 - Level 7 is highest; level 0 masks the source.
// RULE21 - Fast request low while fast flag set and unmasked.
// RULE22 - Normal request negated once number read sets current-level bit.
// RULE23 - Software clears its current-level bit before returning from handler.
// RULE24 - External pins are synchronised before edge detection.
`default_nettype none
package pic_pkg;
  localparam int unsigned NUM_SRC = 24;
  localparam int unsigned NUM_INT = 13;
  localparam logic [5:0] ADR_NUMBER = 6'h00;
  localparam logic [5:0] ADR_CUR_LEVEL = 6'h04;
  localparam logic [5:0] ADR_PEND_LEVEL = 6'h08;
  localparam logic [5:0] ADR_FAST_CTRL = 6'h0c;
  localparam logic [5:0] ADR_SENSE = 6'h10;
  localparam logic [5:0] ADR_FLAGS_LOW = 6'h14;
  localparam logic [5:0] ADR_FLAGS_HIGH = 6'h18;
  localparam logic [5:0] ADR_LEVEL_BASE = 6'h20;
  localparam logic [5:0] ADR_LEVEL_LAST = 6'h34;
  localparam int unsigned FAST_MASK_POS = 2;
  localparam int unsigned FAST_LEVEL_POS = 1;
  localparam int unsigned FAST_FLAG_POS = 0;
  localparam logic [7:0] CUR_LEVEL_RST = 8'h00;
  localparam logic [2:0] PEND_LEVEL_RST = 3'h0;
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [15:0] LEVEL_FIELDS_RST = 16'h0000;
  localparam logic [15:0] LEVEL_FIELD_MASK = 16'h7777;
  localparam logic [15:0] FLAGS_LOW_VALID = 16'h1fff;
  localparam logic [7:0] FLAGS_HIGH_RST = 8'h00;
  localparam logic [15:0] FLAGS_LOW_RST = 16'h0000;
  localparam logic FAST_MASK_RST = 1'b1;

  typedef struct packed {
    logic [4:0] number;
    logic [2:0] level;
    logic       hit;
  } pic_select_type;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pic_wb_req_type;
endpackage
`default_nettype wire

// file: core/pic_pin_sense.sv
// Pin synchroniser with edge or low-level trigger detection.
`default_nettype none
module pic_pin_sense (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_n_i,
  input  wire logic edge_mode_i,
  input  wire logic stop_mode_i,
  output logic      level_o,
  output logic      trigger_o
);
  logic meta;
  logic sync;
  logic prev;

  // Reset to high, so a pin held low through reset shows one falling edge after it.
  always_ff @(posedge clk_i) begin // RULE24
    if (rst_i) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin_n_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  // Stop mode overrides the selection and senses low level.
  assign trigger_o = (edge_mode_i && !stop_mode_i) ? (prev && !sync) // RULE5
                                                   : !sync; // RULE4
endmodule
`default_nettype wire

// file: core/pic_arbiter.sv
// Level and source-number arbitration over all normal sources.
`default_nettype none
module pic_arbiter (
  input  wire logic [23:0]         pending_i,
  input  wire logic [71:0]         levels_i,
  output pic_pkg::pic_select_type  sel_o
);
  always_comb begin
    sel_o = '0;
    // Ascending scan with >= lets larger numbers win ties.
    for (int i = 0; i < 24; i++) begin
      if (pending_i[i] && levels_i[i*3 +: 3] != 3'h0 && // RULE20
          levels_i[i*3 +: 3] >= sel_o.level) begin // RULE7
        sel_o.hit = 1'b1;
        sel_o.level = levels_i[i*3 +: 3];
        sel_o.number = 5'(i);
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/pic_cpu_model.sv
// Processor core model that takes fast and normal exception requests.
`default_nettype none
module pic_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fast_exception_req_n_i,
  input  wire logic normal_exception_req_n_i,
  input  wire logic fast_disable_i,
  input  wire logic normal_disable_i,
  output logic [7:0] fast_taken_o,
  output logic [7:0] normal_taken_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic in_fast;
  logic in_normal;

  // A request is taken once; the core waits for it to drop before the next.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_fast      <= 1'b0;
      fast_taken_o <= 8'h00;
    end else if (fast_exception_req_n_i) begin
      in_fast <= 1'b0;
    end else if (!fast_disable_i && !in_fast) begin
      in_fast      <= 1'b1;
      fast_taken_o <= fast_taken_o + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_normal      <= 1'b0;
      normal_taken_o <= 8'h00;
    end else if (normal_exception_req_n_i) begin
      in_normal <= 1'b0;
    end else if (!normal_disable_i && !in_normal) begin
      in_normal      <= 1'b1;
      normal_taken_o <= normal_taken_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_prioritized_interrupt_controller.sv
// Register-level testbench for the prioritised interrupt controller.
`default_nettype none
module test_prioritized_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o;
  logic ack_o, fpin = 1'b1, stop = 1'b0, fast_exception_req_n, normal_exception_req_n, foff = 1'b0;
  logic [7:0] pins = 8'hff, ftaken, ntaken;
  logic [12:0] ev = 13'h0000;
  int miscompares = 0, checked = 0, cycles = 0;

  always #5 clk_i = ~clk_i;

  pic_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .fast_request_pin_i(fpin), .ext_request_pins_i(pins),
    .int_events_i(ev), .stop_mode_i(stop), .fast_exception_req_n_o(fast_exception_req_n),
    .normal_exception_req_n_o(normal_exception_req_n));

  pic_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i),
    .fast_exception_req_n_i(fast_exception_req_n), .normal_exception_req_n_i(normal_exception_req_n),
    .fast_disable_i(foff), .normal_disable_i(1'b0),
    .fast_taken_o(ftaken), .normal_taken_o(ntaken));

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ack and read data are registered by non-blocking assignment, so what is
  // read right after a rising edge is what that edge sampled; the request
  // is held until that edge sees ack and released only then.
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check($sformatf("reg %h", a), q, exp);
  endtask

  task automatic pulse(input logic [12:0] v);
    @(posedge clk_i); ev <= v;
    @(posedge clk_i); ev <= 13'h0000;
    repeat (4) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(pic_pkg::ADR_CUR_LEVEL, 32'h00);
    rd(pic_pkg::ADR_PEND_LEVEL, 32'h00);
    rd(pic_pkg::ADR_FAST_CTRL, 32'h06);
    rd(pic_pkg::ADR_SENSE, 32'h00);
    rd(pic_pkg::ADR_FLAGS_LOW, 32'h0000);
    rd(pic_pkg::ADR_FLAGS_HIGH, 32'h00);
    for (int i = 0; i < 6; i++)
      rd(pic_pkg::ADR_LEVEL_BASE + 6'(4 * i), 32'h0000);
    rd(6'h3c, 32'h0);
    wr(pic_pkg::ADR_LEVEL_LAST, 32'hffff);
    rd(pic_pkg::ADR_LEVEL_LAST, 32'h7777);
    // Source 5 at level 3; sources 2 and 9 at level 2.
    wr(pic_pkg::ADR_LEVEL_BASE + 6'h04, 32'h0030);
    wr(pic_pkg::ADR_LEVEL_BASE + 6'h08, 32'h0020);
    wr(pic_pkg::ADR_LEVEL_BASE, 32'h0200);
    pulse(13'h0020);
    check("normal_exception_req_n", 32'(normal_exception_req_n), 32'h0);
    rd(pic_pkg::ADR_FLAGS_LOW, 32'h0020);
    rd(pic_pkg::ADR_PEND_LEVEL, 32'h03);
    rd(pic_pkg::ADR_NUMBER, 32'h05);
    check("normal_exception_req_n", 32'(normal_exception_req_n), 32'h1);
    rd(pic_pkg::ADR_CUR_LEVEL, 32'h08);
    rd(pic_pkg::ADR_PEND_LEVEL, 32'h00);
    check("ntaken", 32'(ntaken), 32'h1);
    pulse(13'h0204);
    check("normal_exception_req_n", 32'(normal_exception_req_n), 32'h1);
    rd(pic_pkg::ADR_FLAGS_LOW, 32'h0224);
    wr(pic_pkg::ADR_FLAGS_LOW, 32'h0020);
    wr(pic_pkg::ADR_CUR_LEVEL, 32'h08);
    repeat (3) @(posedge clk_i);
    check("normal_exception_req_n", 32'(normal_exception_req_n), 32'h0);
    rd(pic_pkg::ADR_PEND_LEVEL, 32'h02);
    rd(pic_pkg::ADR_NUMBER, 32'h09);
    rd(pic_pkg::ADR_CUR_LEVEL, 32'h04);
    wr(pic_pkg::ADR_CUR_LEVEL, 32'h04);
    wr(pic_pkg::ADR_FLAGS_LOW, 32'h0204);
    rd(pic_pkg::ADR_FLAGS_LOW, 32'h0000);
    rd(pic_pkg::ADR_PEND_LEVEL, 32'h00);
    pulse(13'h0001);
    rd(pic_pkg::ADR_FLAGS_LOW, 32'h0001);
    check("normal_exception_req_n", 32'(normal_exception_req_n), 32'h1);
    wr(pic_pkg::ADR_FLAGS_LOW, 32'h0001);
    // Pin 0 edge sensed, pin 7 level sensed, both at level 6.
    wr(pic_pkg::ADR_SENSE, 32'h01);
    wr(pic_pkg::ADR_LEVEL_BASE + 6'h10, 32'h0006);
    wr(pic_pkg::ADR_LEVEL_LAST, 32'h6000);
    @(posedge clk_i); pins <= 8'h7e;
    repeat (6) @(posedge clk_i); pins <= 8'hff;
    repeat (6) @(posedge clk_i);
    rd(pic_pkg::ADR_FLAGS_HIGH, 32'h81);
    rd(pic_pkg::ADR_NUMBER, 32'h17);
    wr(pic_pkg::ADR_CUR_LEVEL, 32'h40);
    wr(pic_pkg::ADR_FLAGS_HIGH, 32'h80);
    repeat (3) @(posedge clk_i);
    check("normal_exception_req_n", 32'(normal_exception_req_n), 32'h0);
    rd(pic_pkg::ADR_NUMBER, 32'h10);
    wr(pic_pkg::ADR_CUR_LEVEL, 32'h40);
    wr(pic_pkg::ADR_FLAGS_HIGH, 32'h01);
    rd(pic_pkg::ADR_FLAGS_HIGH, 32'h00);
    // In stop mode an edge-sensed pin held low keeps re-raising its flag.
    @(posedge clk_i); stop <= 1'b1; pins <= 8'hfe;
    repeat (6) @(posedge clk_i);
    wr(pic_pkg::ADR_FLAGS_HIGH, 32'h01);
    rd(pic_pkg::ADR_FLAGS_HIGH, 32'h01);
    @(posedge clk_i); stop <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr(pic_pkg::ADR_FLAGS_HIGH, 32'h01);
    rd(pic_pkg::ADR_FLAGS_HIGH, 32'h00);
    @(posedge clk_i); pins <= 8'hff; foff <= 1'b1; fpin <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("fast_exception_req_n", 32'(fast_exception_req_n), 32'h1);
    rd(pic_pkg::ADR_FAST_CTRL, 32'h05);
    wr(pic_pkg::ADR_FAST_CTRL, 32'h02);
    repeat (2) @(posedge clk_i);
    check("fast_exception_req_n", 32'(fast_exception_req_n), 32'h0);
    rd(pic_pkg::ADR_FAST_CTRL, 32'h01);
    check("ftaken", 32'(ftaken), 32'h0);
    @(posedge clk_i); foff <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("ftaken", 32'(ftaken), 32'h1);
    wr(pic_pkg::ADR_FAST_CTRL, 32'h01);
    repeat (2) @(posedge clk_i);
    check("fast_exception_req_n", 32'(fast_exception_req_n), 32'h1);
    rd(pic_pkg::ADR_FAST_CTRL, 32'h00);
    @(posedge clk_i); fpin <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(pic_pkg::ADR_FAST_CTRL, 32'h02);
    give_verdict();
  end
endmodule
`default_nettype wire
